// ===== link_throughput_monitor.sv
`timescale 1ns/10ps
`include "link_throughput_monitor_defines.svh"

module link_throughput_monitor
  import link_throughput_monitor_pkg::*;
#(
  parameter int NUM_ENGINES = 2,
  parameter int TICK_CYCLES = `REPORT_INTERVAL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // outbound (card_to_system) transaction interface
  input wire link_throughput_monitor_pkg::beat_t tx_data,
  input wire link_throughput_monitor_pkg::keep_t tx_keep,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_last,
  // inbound (system_to_card) transaction interface
  input wire link_throughput_monitor_pkg::beat_t rx_data,
  input wire link_throughput_monitor_pkg::keep_t rx_keep,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_last,
  // dma engines' user-side streams
  input wire link_throughput_monitor_pkg::keep_t [NUM_ENGINES-1:0] eng_keep,
  input wire logic [NUM_ENGINES-1:0] eng_valid,
  input wire logic [NUM_ENGINES-1:0] eng_ready,
  // published counts, bytes in last second
  output link_throughput_monitor_pkg::count_t tx_total_bytes,
  output link_throughput_monitor_pkg::count_t rx_total_bytes,
  output link_throughput_monitor_pkg::count_t tx_payload_bytes,
  output link_throughput_monitor_pkg::count_t rx_payload_bytes,
  output link_throughput_monitor_pkg::count_t [NUM_ENGINES-1:0] eng_bytes,
  output logic counts_updated
);
  import link_throughput_monitor_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  logic [TICK_W-1:0] tick_cnt;
  logic tick;

  // one-second tick derived from clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counts_updated <= 1'b0;
    end else begin
      counts_updated <= tick;
    end
  end

  // valid bytes of a beat from its byte enables
  function automatic logic [15:0] keep_bytes(input keep_t k);
    logic [15:0] n;
    n = '0;
    for (int i = 0; i < `KEEP_BITS; i++) begin
      n = n + 16'(k[i]);
    end
    return n;
  endfunction : keep_bytes

  logic tx_fire;
  logic rx_fire;
  logic tx_first;
  logic rx_first;
  logic [15:0] tx_beat_bytes;
  logic [15:0] rx_beat_bytes;

  assign tx_fire = tx_valid && tx_ready;
  assign rx_fire = rx_valid && rx_ready;
  assign tx_beat_bytes = tx_fire ? keep_bytes(tx_keep) : 16'h0000;
  assign rx_beat_bytes = rx_fire ? keep_bytes(rx_keep) : 16'h0000;

  // start-of-packet trackers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_first <= 1'b1;
    end else if (tx_fire) begin
      tx_first <= tx_last;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_first <= 1'b1;
    end else if (rx_fire) begin
      rx_first <= rx_last;
    end
  end

  // header decode of first beat: header length and payload class
  logic tx_is_mwr;
  logic rx_is_cpld;
  logic [15:0] tx_hdr_len;
  logic [15:0] rx_hdr_len;

  assign tx_is_mwr = tx_data[`HDR_FMT_DATA_BIT] &&
    (tx_data[`HDR_TYPE_MSB:`HDR_TYPE_LSB] == `TYPE_MEM);
  assign rx_is_cpld = rx_data[`HDR_FMT_DATA_BIT] &&
    (rx_data[`HDR_TYPE_MSB:`HDR_TYPE_LSB] == `TYPE_CPL);
  assign tx_hdr_len = tx_data[`HDR_FMT_4DW_BIT] ? `HDR_BYTES_4DW : `HDR_BYTES_3DW;
  assign rx_hdr_len = rx_data[`HDR_FMT_4DW_BIT] ? `HDR_BYTES_4DW : `HDR_BYTES_3DW;

  pkt_state_t tx_state;
  pkt_state_t rx_state;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= idle_pkt;
    end else if (tx_fire) begin
      case (tx_state)
        idle_pkt: begin
          if (tx_last) begin
            tx_state <= idle_pkt;
          end else begin
            tx_state <= tx_is_mwr ? payload_pkt : header_only_pkt;
          end
        end
        payload_pkt, header_only_pkt: begin
          if (tx_last) begin
            tx_state <= idle_pkt;
          end
        end
        default: tx_state <= idle_pkt;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= idle_pkt;
    end else if (rx_fire) begin
      case (rx_state)
        idle_pkt: begin
          if (rx_last) begin
            rx_state <= idle_pkt;
          end else begin
            rx_state <= rx_is_cpld ? payload_pkt : header_only_pkt;
          end
        end
        payload_pkt, header_only_pkt: begin
          if (rx_last) begin
            rx_state <= idle_pkt;
          end
        end
        default: rx_state <= idle_pkt;
      endcase
    end
  end

  // payload bytes of memory-write (tx) and completion-with-data (rx) packets: first beat less its header, later beats whole
  logic [15:0] tx_pay;
  logic [15:0] rx_pay;

  always_comb begin
    tx_pay = 16'h0000;
    if (tx_fire) begin
      if (tx_first) begin
        if (tx_is_mwr && tx_beat_bytes > tx_hdr_len) begin
          tx_pay = tx_beat_bytes - tx_hdr_len;
        end
      end else if (tx_state == payload_pkt) begin
        tx_pay = tx_beat_bytes;
      end
    end
  end

  always_comb begin
    rx_pay = 16'h0000;
    if (rx_fire) begin
      if (rx_first) begin
        if (rx_is_cpld && rx_beat_bytes > rx_hdr_len) begin
          rx_pay = rx_beat_bytes - rx_hdr_len;
        end
      end else if (rx_state == payload_pkt) begin
        rx_pay = rx_beat_bytes;
      end
    end
  end

  beat_byte_counter #(.WIDTH(`COUNT_BITS), .ADD_WIDTH(16)) u_tx_total (
    .clk(clk), .rst(rst), .add_bytes(tx_beat_bytes), .tick(tick), .count(tx_total_bytes)
  );
  beat_byte_counter #(.WIDTH(`COUNT_BITS), .ADD_WIDTH(16)) u_rx_total (
    .clk(clk), .rst(rst), .add_bytes(rx_beat_bytes), .tick(tick), .count(rx_total_bytes)
  );
  beat_byte_counter #(.WIDTH(`COUNT_BITS), .ADD_WIDTH(16)) u_tx_pay (
    .clk(clk), .rst(rst), .add_bytes(tx_pay), .tick(tick), .count(tx_payload_bytes)
  );
  beat_byte_counter #(.WIDTH(`COUNT_BITS), .ADD_WIDTH(16)) u_rx_pay (
    .clk(clk), .rst(rst), .add_bytes(rx_pay), .tick(tick), .count(rx_payload_bytes)
  );

  // one completed byte counter per dma engine
  for (genvar g = 0; g < NUM_ENGINES; g++) begin : g_eng
    logic [15:0] eng_add;
    assign eng_add = (eng_valid[g] && eng_ready[g]) ? keep_bytes(eng_keep[g]) : 16'h0000;
    beat_byte_counter #(.WIDTH(`COUNT_BITS), .ADD_WIDTH(16)) u_eng (
      .clk(clk), .rst(rst), .add_bytes(eng_add), .tick(tick), .count(eng_bytes[g])
    );
  end

endmodule : link_throughput_monitor

// ===== link_throughput_monitor_defines.svh
`ifndef LINK_THROUGHPUT_MONITOR_DEFINES_SVH
`define LINK_THROUGHPUT_MONITOR_DEFINES_SVH

// clock rate and the reporting interval
`define CLK_FREQ_HZ 200000000
`define REPORT_INTERVAL_S 1
`define REPORT_INTERVAL_CYCLES (`CLK_FREQ_HZ * `REPORT_INTERVAL_S)

// transaction interface geometry
`define BEAT_BITS 128
`define BEAT_BYTES 16
`define KEEP_BITS 16
`define COUNT_BITS 32
`define BEAT_CNT_BITS 5

// tlp header decode: fmt/type sit in the first dword of the first beat
`define HDR_FMT_MSB 31
`define HDR_FMT_LSB 29
`define HDR_TYPE_MSB 28
`define HDR_TYPE_LSB 24
`define HDR_LEN_MSB 9
`define HDR_LEN_LSB 0
`define HDR_FMT_DATA_BIT 30
`define HDR_FMT_4DW_BIT 29
`define TYPE_MEM 5'h00
`define TYPE_CPL 5'h0a
`define HDR_BYTES_3DW 16'h000c
`define HDR_BYTES_4DW 16'h0010
`define DW_BYTES_SHIFT 2

`endif

// ===== link_throughput_monitor_pkg.sv
package link_throughput_monitor_pkg;
  `include "link_throughput_monitor_defines.svh"

  typedef logic [`COUNT_BITS-1:0] count_t;
  typedef logic [`KEEP_BITS-1:0] keep_t;
  typedef logic [`BEAT_BITS-1:0] beat_t;
  typedef logic [`BEAT_CNT_BITS-1:0] beat_cnt_t;

  // payload classification of the packet in flight
  typedef enum logic [1:0] {
    idle_pkt,
    payload_pkt,
    header_only_pkt
  } pkt_state_t;
endpackage : link_throughput_monitor_pkg

// ===== beat_byte_counter.sv
`timescale 1ns/10ps
`include "link_throughput_monitor_defines.svh"

// one accumulator: adds a per-cycle byte amount, dumps and restarts on tick
module beat_byte_counter #(
  parameter int WIDTH = `COUNT_BITS,
  parameter int ADD_WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // accumulation
  input wire logic [ADD_WIDTH-1:0] add_bytes,
  input wire logic tick,
  // published count
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] running;
  logic [WIDTH-1:0] add_ext;

  assign add_ext = WIDTH'(add_bytes);

  // bytes of the tick cycle start the next interval rather than being lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= '0;
    end else if (tick) begin
      running <= add_ext;
    end else begin
      running <= running + add_ext;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (tick) begin
      count <= running;
    end
  end

endmodule : beat_byte_counter

// ===== ltm_checker.sv
`timescale 1ns/10ps
`include "link_throughput_monitor_defines.svh"
module ltm_checker
  import link_throughput_monitor_pkg::*;
#(
  parameter int NUM_ENGINES = 2,
  parameter int TICK_CYCLES = `REPORT_INTERVAL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams
  input wire keep_t tx_keep,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire keep_t rx_keep,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire keep_t [NUM_ENGINES-1:0] eng_keep,
  input wire logic [NUM_ENGINES-1:0] eng_valid,
  input wire logic [NUM_ENGINES-1:0] eng_ready,
  // counts
  input wire count_t tx_total_bytes,
  input wire count_t rx_total_bytes,
  input wire count_t tx_payload_bytes,
  input wire count_t rx_payload_bytes,
  input wire count_t [NUM_ENGINES-1:0] eng_bytes,
  input wire logic counts_updated
);
  int ph;
  logic seen;
  count_t at, ar, ae, st, sr, se;
  wire tk = ph == TICK_CYCLES - 1;
  // reference sums; a beat on the tick edge opens the new interval
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 0;
      seen <= 1'b0;
      at <= '0;
      ar <= '0;
      ae <= '0;
    end else begin
      ph <= tk ? 0 : ph + 1;
      at <= (tk ? '0 : at) + count_t'((tx_valid & tx_ready) ? $countones(tx_keep) : 0);
      ar <= (tk ? '0 : ar) + count_t'((rx_valid & rx_ready) ? $countones(rx_keep) : 0);
      ae <= (tk ? '0 : ae) + count_t'((eng_valid[0] & eng_ready[0]) ? $countones(eng_keep[0]) : 0);
      if (tk) begin
        seen <= 1'b1;
        st <= at;
        sr <= ar;
        se <= ae;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pulse;
    counts_updated ##1 !counts_updated;
  endsequence
  a_tx_total_sum: assert property (counts_updated |-> tx_total_bytes == st)
    else $error("tx total wrong");
  a_rx_total_sum: assert property (counts_updated |-> rx_total_bytes == sr)
    else $error("rx total wrong");
  a_tx_pay_bound: assert property (counts_updated |-> tx_payload_bytes <= tx_total_bytes)
    else $error("tx payload above total");
  a_rx_pay_bound: assert property (counts_updated |-> rx_payload_bytes <= rx_total_bytes)
    else $error("rx payload above total");
  a_eng_bytes_sum: assert property (counts_updated |-> eng_bytes[0] == se)
    else $error("engine count wrong");
  a_pulse_phase: assert property (counts_updated == (ph == 0 && seen))
    else $error("publish off schedule");
  a_pulse_single: assert property (counts_updated |-> s_pulse)
    else $error("pulse too long");
  a_counts_hold: assert property (!counts_updated |-> $stable(tx_total_bytes) && $stable(eng_bytes))
    else $error("count moved between ticks");
endmodule : ltm_checker

bind link_throughput_monitor ltm_checker #(.NUM_ENGINES(NUM_ENGINES), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rst(rst),
  .tx_keep(tx_keep), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_keep(rx_keep), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .eng_keep(eng_keep), .eng_valid(eng_valid), .eng_ready(eng_ready),
  .tx_total_bytes(tx_total_bytes), .rx_total_bytes(rx_total_bytes),
  .tx_payload_bytes(tx_payload_bytes), .rx_payload_bytes(rx_payload_bytes),
  .eng_bytes(eng_bytes), .counts_updated(counts_updated)
);

// ===== tlp_source_model.sv
`timescale 1ns/10ps
module tlp_source_model
  import link_throughput_monitor_pkg::*;
(
  // clock and handshake
  input wire logic clk,
  input wire logic ready,
  // beat
  output link_throughput_monitor_pkg::beat_t data,
  output link_throughput_monitor_pkg::keep_t keep,
  output logic valid,
  output logic last
);
  initial begin
    data = '0;
    keep = '0;
    valid = 1'b0;
    last = 1'b0;
  end
  task automatic hold;
    int n;
    n = 0;
    @(posedge clk);
    while (!ready && n < 16) begin
      @(posedge clk);
      n++;
    end
  endtask : hold
  // header beat, then a tail beat with byte enables k1
  task automatic send(input logic [31:0] hdr, input keep_t k1);
    @(negedge clk);
    data <= {~data[127:32], hdr};
    keep <= 16'hffff;
    valid <= 1'b1;
    hold();
    @(negedge clk);
    data <= ~data;
    keep <= k1;
    last <= 1'b1;
    hold();
    @(negedge clk);
    data <= ~data;
    valid <= 1'b0;
    last <= 1'b0;
  endtask : send
endmodule : tlp_source_model

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  import link_throughput_monitor_pkg::*;
  localparam int TICK = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  beat_t tx_data, rx_data;
  keep_t tx_keep, rx_keep;
  logic tx_valid, tx_ready, tx_last, rx_valid, rx_ready, rx_last, counts_updated;
  keep_t [1:0] eng_keep;
  logic [1:0] eng_valid, eng_ready;
  count_t tx_total_bytes, rx_total_bytes, tx_payload_bytes, rx_payload_bytes;
  count_t [1:0] eng_bytes;
  int miscompares = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  link_throughput_monitor #(.NUM_ENGINES(2), .TICK_CYCLES(TICK)) u_dut (
    .clk(clk), .rst(rst),
    .tx_data(tx_data), .tx_keep(tx_keep), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last),
    .rx_data(rx_data), .rx_keep(rx_keep), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_last(rx_last),
    .eng_keep(eng_keep), .eng_valid(eng_valid), .eng_ready(eng_ready),
    .tx_total_bytes(tx_total_bytes), .rx_total_bytes(rx_total_bytes),
    .tx_payload_bytes(tx_payload_bytes), .rx_payload_bytes(rx_payload_bytes),
    .eng_bytes(eng_bytes), .counts_updated(counts_updated)
  );
  tlp_source_model u_tx (.clk(clk), .ready(tx_ready), .data(tx_data), .keep(tx_keep), .valid(tx_valid), .last(tx_last));
  tlp_source_model u_rx (.clk(clk), .ready(rx_ready), .data(rx_data), .keep(rx_keep), .valid(rx_valid), .last(rx_last));
  task automatic chk(input count_t got, input count_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic wait_pub(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (counts_updated !== 1'b1 && n < 2 * TICK);
    if (counts_updated !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask : wait_pub
  task automatic test_mixed;
    int n;
    fork
      begin
        u_tx.send(32'h40000000, 16'h00ff);
        u_tx.send(32'h60000000, 16'hffff);
        u_tx.send(32'h00000000, 16'h000f);
      end
      begin
        u_rx.send(32'h4a000000, 16'h000f);
        u_rx.send(32'h0a000000, 16'h0001);
        u_rx.send(32'h40000000, 16'h0003);
      end
      begin
        repeat (5) @(negedge clk);
        tx_ready <= 1'b0;
        repeat (3) @(negedge clk);
        tx_ready <= 1'b1;
      end
      begin
        @(negedge clk);
        eng_valid <= 2'b11;
        eng_ready <= 2'b01;
        eng_keep <= {16'h000f, 16'hffff};
        repeat (2) @(negedge clk);
        eng_ready <= 2'b11;
        repeat (2) @(negedge clk);
        eng_valid <= 2'b00;
      end
    join
    wait_pub(n);
    chk(tx_total_bytes, 32'h4c);
    chk(tx_payload_bytes, 32'h1c);
    chk(rx_total_bytes, 32'h37);
    chk(rx_payload_bytes, 32'h8);
    chk(eng_bytes[0], 32'h40);
    chk(eng_bytes[1], 32'h8);
    $display("test_mixed done");
  endtask : test_mixed
  task automatic test_idle;
    int n;
    wait_pub(n);
    chk(32'(n), 32'(TICK));
    chk(tx_total_bytes, 32'h0);
    chk(rx_payload_bytes, 32'h0);
    chk(eng_bytes[1], 32'h0);
    $display("test_idle done");
  endtask : test_idle
  task automatic test_tick_edge;
    int n;
    // entered just after a publication: one beat before the tick edge, one on it
    repeat (TICK - 2) @(negedge clk);
    eng_keep <= {16'h0003, 16'h0000};
    eng_valid <= 2'b10;
    @(negedge clk);
    wait_pub(n);
    eng_valid <= 2'b00;
    chk(eng_bytes[1], 32'h2);
    chk(eng_bytes[0], 32'h0);
    wait_pub(n);
    chk(32'(n), 32'(TICK));
    chk(eng_bytes[1], 32'h2);
    $display("test_tick_edge done");
  endtask : test_tick_edge
  initial begin
    tx_ready = 1'b1;
    rx_ready = 1'b1;
    eng_keep = '0;
    eng_valid = 2'b00;
    eng_ready = 2'b00;
    repeat (5) @(negedge clk);
    rst <= 1'b0;
    chk(tx_total_bytes, 32'h0);
    test_mixed();
    test_idle();
    test_tick_edge();
    summarize();
  end
endmodule : testbench
